// ---- shared/lls_regs.svh ----
`ifndef LLS_REGS_SVH
`define LLS_REGS_SVH
`define LLS_OFS_CODE_CH9 8'h07
`define LLS_OFS_SEL_LOW 8'h08
`define LLS_RST_CODE_CH9 8'h00
`define LLS_RST_SEL_LOW 8'h00
`define LLS_CH9_BIT 6
`define LLS_CODE_MSB 5
`define LLS_CODE_PWM 6'h3F
`define LLS_DIV_BASE 7'h08
`define LLS_DIV_UNITY 7'h0A
`define LLS_DIV_TOP 7'h46
`endif

// ---- shared/lls_pkg.sv ----
package lls_pkg;
    typedef struct packed {
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lls_wr_t;
    typedef struct packed {
        logic [8:0] reduced;
        logic [8:0] pwm_gate;
        logic [6:0] divisor_tenths;
    } lls_ctl_t;
endpackage

// ---- logic/lls_level_select.sv ----
`timescale 1ns/1ns
`include "lls_regs.svh"
// Contract
// R1 - bit 6 of first register selects shared level code for channel nine, else 25 mA
// R2 - six-bit shared code in bits 5:0 applies to every selected channel
// R3 - codes 0 to 62 give divisor 0.8 plus 0.1 per step
// R4 - code 63 is PWM mode; interrupt pin gates selected outputs directly
// R5 - second register bits 7:0 select channels 8 down to 1
// R6 - reserved top bit of first register ignores writes, reads zero
module lls_level_select
    import lls_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire lls_wr_t wr,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic pwm_pin,
    output lls_ctl_t ctl
);
    // ***********************
    // register storage
    // ***********************
    // bit 7 of the first register is never stored, so it cannot leak out
    logic [6:0] level_code_and_ch9_select;
    logic [7:0] channel_level_select_low;
    logic [6:0] next_level_code_and_ch9_select;
    logic [7:0] next_channel_level_select_low;
    logic hit_code;
    logic hit_low;

    assign hit_code = wr.wr_en && (wr.addr == `LLS_OFS_CODE_CH9);
    assign hit_low = wr.wr_en && (wr.addr == `LLS_OFS_SEL_LOW);

    always_comb begin
        next_level_code_and_ch9_select = level_code_and_ch9_select;
        next_channel_level_select_low = channel_level_select_low;
        if (hit_code) begin
            next_level_code_and_ch9_select = wr.wdata[6:0]; // [R6]
        end
        if (hit_low) begin
            next_channel_level_select_low = wr.wdata; // [R5]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            level_code_and_ch9_select <= 7'(`LLS_RST_CODE_CH9);
            channel_level_select_low <= `LLS_RST_SEL_LOW;
        end else begin
            level_code_and_ch9_select <= next_level_code_and_ch9_select;
            channel_level_select_low <= next_channel_level_select_low;
        end
    end

    // ***********************
    // pwm pin synchroniser
    // ***********************
    // the pin is asynchronous; only the second flop feeds logic
    logic pwm_s1;
    logic pwm_s2;
    logic next_pwm_s1;
    logic next_pwm_s2;

    always_comb begin
        next_pwm_s1 = pwm_pin;
        next_pwm_s2 = pwm_s1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwm_s1 <= 1'b0;
            pwm_s2 <= 1'b0;
        end else begin
            pwm_s1 <= next_pwm_s1;
            pwm_s2 <= next_pwm_s2;
        end
    end

    // ***********************
    // readback
    // ***********************
    // reads are combinational so software sees the stored value same cycle
    always_comb begin
        case (rd_addr)
            `LLS_OFS_CODE_CH9: begin
                rd_data = {1'b0, level_code_and_ch9_select}; // [R6]
            end
            `LLS_OFS_SEL_LOW: begin
                rd_data = channel_level_select_low; // [R5]
            end
            default: begin
                rd_data = 8'h00;
            end
        endcase
    end

    // ***********************
    // decode
    // ***********************
    logic [5:0] code;
    logic ch9_scale_enable;
    logic [8:0] per_channel_scale_enable;
    logic is_pwm;

    assign code = level_code_and_ch9_select[`LLS_CODE_MSB:0]; // [R2]
    assign ch9_scale_enable = level_code_and_ch9_select[`LLS_CH9_BIT]; // [R1]
    assign per_channel_scale_enable = {ch9_scale_enable, channel_level_select_low}; // [R1] [R5]
    assign is_pwm = (code == `LLS_CODE_PWM); // [R4]

    // ***********************
    // per-channel controls
    // ***********************
    // an unselected channel keeps full scale whatever the shared code says
    logic [8:0] next_reduced;
    logic [8:0] next_pwm_gate;

    genvar ch;
    generate
        for (ch = 0; ch < 9; ch++) begin : g_chan
            assign next_reduced[ch] = per_channel_scale_enable[ch] & ~is_pwm; // [R2]
            assign next_pwm_gate[ch] = per_channel_scale_enable[ch] & is_pwm & pwm_s2; // [R4]
        end
    endgenerate

    // ***********************
    // control register
    // ***********************
    lls_ctl_t next_ctl;

    always_comb begin
        next_ctl.reduced = next_reduced; // [R2]
        next_ctl.pwm_gate = next_pwm_gate; // [R4]
        // divisor in tenths: base plus code; pwm reports unity
        if (is_pwm) begin
            next_ctl.divisor_tenths = `LLS_DIV_UNITY; // [R4]
        end else begin
            next_ctl.divisor_tenths = `LLS_DIV_BASE + {1'b0, code}; // [R3]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctl <= '0;
        end else begin
            ctl <= next_ctl;
        end
    end

    // ***********************
    // checks
    // ***********************
    sequence seq_pwm_held;
        (is_pwm && per_channel_scale_enable[0]) ##1 (is_pwm && per_channel_scale_enable[0]);
    endsequence

    sequence seq_code_write;
        hit_code;
    endsequence

    chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
        rd_addr == `LLS_OFS_CODE_CH9 |-> rd_data[7] == 1'b0)
        else $error("reserved bit read nonzero");

    chk_ch9_reduced: assert property (@(posedge clk_sys) disable iff (rst) // [R1]
        (ch9_scale_enable && !is_pwm) |=> ctl.reduced[8])
        else $error("ch9 not reduced");

    chk_ch9_full: assert property (@(posedge clk_sys) disable iff (rst) // [R1]
        !ch9_scale_enable |=> (!ctl.reduced[8] && !ctl.pwm_gate[8]))
        else $error("ch9 not full scale");

    chk_low_reduced: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
        !is_pwm |=> ctl.reduced[7:0] == $past(channel_level_select_low))
        else $error("low select mismatch");

    chk_divisor: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
        !is_pwm |=> ctl.divisor_tenths == 7'(8 + $past(code)))
        else $error("divisor wrong");

    chk_divisor_range: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
        !is_pwm |=> (ctl.divisor_tenths >= `LLS_DIV_BASE && ctl.divisor_tenths <= `LLS_DIV_TOP))
        else $error("divisor out of range");

    chk_pwm_gate: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
        is_pwm |=> ctl.pwm_gate == ($past(per_channel_scale_enable) & {9{$past(pwm_s2)}}))
        else $error("pwm gate wrong");

    chk_pwm_unity: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
        is_pwm |=> ctl.divisor_tenths == `LLS_DIV_UNITY)
        else $error("pwm divisor not unity");

    chk_no_reduce_pwm: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
        is_pwm |=> ctl.reduced == 9'h000)
        else $error("reduced in pwm");

    chk_no_gate_normal: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
        !is_pwm |=> ctl.pwm_gate == 9'h000)
        else $error("gate outside pwm");

    chk_write_takes: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
        hit_low |=> channel_level_select_low == $past(wr.wdata))
        else $error("write lost");

    chk_code_takes: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
        seq_code_write |=> level_code_and_ch9_select == $past(wr.wdata[6:0]))
        else $error("code write lost");

    chk_low_readback: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
        rd_addr == `LLS_OFS_SEL_LOW |-> rd_data == channel_level_select_low)
        else $error("low readback wrong");

    chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
        (rd_addr != `LLS_OFS_CODE_CH9 && rd_addr != `LLS_OFS_SEL_LOW) |-> rd_data == 8'h00)
        else $error("unmapped read nonzero");

    chk_reset_clear: assert property (@(posedge clk_sys) // [R2]
        rst |=> ctl == '0)
        else $error("control not cleared");

    // pin to gate: two sync flops plus the control register
    chk_pin_latency: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
        seq_pwm_held |=> ctl.pwm_gate[0] == $past(pwm_pin, 3))
        else $error("pin lag");

endmodule // lls_level_select

// ---- bench/lls_pwm_src.sv ----
`timescale 1ns/1ns
// ****
// pwm source on the shared pin
// ****
module lls_pwm_src (
    input wire logic clk_sys,
    input wire logic run,
    output logic pwm_pin
);
    initial pwm_pin = 1'b0;
    // held still while the bench checks
    always @(posedge clk_sys) if (run) pwm_pin <= ~pwm_pin;
endmodule // lls_pwm_src

// ---- bench/led_output_level_select_test.sv ----
`timescale 1ns/1ns
`include "lls_regs.svh"
// ****
// bench
// ****
module led_output_level_select_test import lls_pkg::*;;
    logic clk_sys = 1'b0, rst = 1'b1, run = 1'b1, pwm_pin;
    lls_wr_t wr = '0;
    logic [7:0] rd_addr = 8'h07, rd_data;
    lls_ctl_t ctl;
    int miscompares = 0, check_count = 0;
    always #2 clk_sys = ~clk_sys;
    lls_level_select dut (.clk_sys(clk_sys), .rst(rst), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
        .pwm_pin(pwm_pin), .ctl(ctl));
    lls_pwm_src src (.clk_sys(clk_sys), .run(run), .pwm_pin(pwm_pin));
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        wr <= '{1'b1, a, d};
        @(posedge clk_sys);
    endtask
    task automatic cmp_ctl(input lls_ctl_t e, input lls_ctl_t s);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch ctl expected %h seen %h", e, s);
        end
    endtask
    task automatic cmp_rd(input string n, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic lls_ctl_t exp_ctl(input logic [5:0] c, input logic [8:0] s, input logic p);
        return (c == `LLS_CODE_PWM) ? '{9'h000, s & {9{p}}, `LLS_DIV_UNITY} : '{s, 9'h000, `LLS_DIV_BASE + 7'(c)};
    endfunction
    task automatic trial(input logic [7:0] a, input logic [7:0] b, input string n);
        run <= 1'b1;
        put(8'h07, a);
        put(8'h08, b);
        put(8'h09, ~a);
        wr <= '0;
        run <= 1'b0;
        // two sync flops plus the output register
        repeat (4) @(posedge clk_sys);
        #1;
        cmp_ctl(exp_ctl(a[5:0], {a[6], b}, pwm_pin), ctl);
        cmp_rd("rd code", a & 8'h7F, rd_data);
        @(posedge clk_sys);
        rd_addr <= 8'h08;
        @(posedge clk_sys);
        #1;
        cmp_rd("rd low", b, rd_data);
        @(posedge clk_sys);
        rd_addr <= 8'h07;
        $display("test %s done", n);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        give_verdict;
    end
    initial begin
        void'($urandom(32'h1AA7));
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        trial(8'hFF, 8'hA5, "pwm reserved");
        trial(8'h7E, 8'hFF, "divisor max");
        trial(8'h40, 8'h01, "code zero");
        repeat (40) trial(8'($urandom), 8'($urandom), "random");
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        cmp_ctl('0, ctl);
        cmp_rd("rd reset", 8'h00, rd_data);
        @(posedge clk_sys);
        rst <= 1'b0;
        trial(8'h3F, 8'h81, "pwm after reset");
        rd_addr <= 8'h09;
        @(posedge clk_sys);
        #1;
        cmp_rd("unmapped", 8'h00, rd_data);
        give_verdict;
    end
endmodule // led_output_level_select_test
